// *** hw/eth_dma_defines.vh ***
`ifndef ETH_DMA_DEFINES_VH
`define ETH_DMA_DEFINES_VH

// ********************************
// Register map (byte addresses)
// ********************************
`define GRP_HEAD 2'h0
`define GRP_CP 2'h1
`define REG_TX_RAW 8'h80
`define REG_RX_RAW 8'h84
`define REG_TX_MSET 8'h88
`define REG_TX_MCLR 8'h8C
`define REG_RX_MSET 8'h90
`define REG_RX_MCLR 8'h94
`define REG_CTRL 8'h98
`define REG_TEARDOWN 8'h9C
`define CTRL_RESET 3'h0
`define CTRL_IRQ_EN 0
`define CTRL_TX_EN 1
`define CTRL_RX_EN 2

// ********************************
// Descriptor layout
// ********************************
`define DESC_W3_OFS 32'h0000000C
`define FLAG_SOP 31
`define FLAG_EOP 30
`define FLAG_HOLDS 29
`define FLAG_EOQ 28
`define FLAG_TD 27
`define FLAG_CRC 26

`endif

// *** hw/chan_queue.v ***
// ********************************
// One channel's queue state
// ********************************
module chan_queue (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Software side
    input wire i_head_wr,
    input wire i_cp_wr,
    input wire [31:0] i_wdata,
    // Engine side
    input wire i_adv,
    input wire i_halt,
    input wire i_done,
    input wire [31:0] i_ptr,
    // State
    output reg [31:0] o_head,
    output reg o_active,
    output reg [31:0] o_last,
    output reg [31:0] o_cp,
    output wire o_raw
);
    // Head pointer and run state
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_head <= 32'h00000000;
            o_active <= 1'b0;
        end else if (i_head_wr) begin
            o_head <= i_wdata;
            o_active <= |i_wdata;
        end else if (i_halt) begin
            o_head <= 32'h00000000;
            o_active <= 1'b0;
        end else if (i_adv) begin
            o_head <= i_ptr;
        end
    end

    // Completion pointers
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_last <= 32'h00000000;
            o_cp <= 32'h00000000;
        end else begin
            if (i_done)
                o_last <= i_ptr;
            if (i_cp_wr)
                o_cp <= i_wdata;
        end
    end

    assign o_raw = (o_cp != o_last);
endmodule

// *** hw/rr_pick.v ***
// ********************************
// Round-robin channel picker
// ********************************
module rr_pick #(
    parameter N = 16,
    parameter W = 4
) (
    input wire [N-1:0] i_req,
    input wire [W-1:0] i_last,
    output reg o_any,
    output reg [W-1:0] o_idx
);
    integer k;
    integer j;

    // Nearest requester after the last winner
    always @* begin
        o_any = |i_req;
        o_idx = {W{1'b0}};
        for (k = N; k >= 1; k = k - 1) begin
            j = (i_last + k) % N;
            if (i_req[j])
                o_idx = j[W-1:0];
        end
    end
endmodule

// *** hw/eth_desc_queue_dma.v ***
`include "eth_dma_defines.vh"

// ********************************
// Descriptor queue DMA engine
// ********************************
module eth_desc_queue_dma #(
    parameter NCH = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Avalon-MM register slave
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    // Avalon-MM descriptor master
    output reg [31:0] o_mm_address,
    output reg o_mm_read,
    output reg o_mm_write,
    output reg [31:0] o_mm_writedata,
    input wire [31:0] i_mm_readdata,
    input wire i_mm_waitrequest,
    // Buffer job to frame engine
    output reg o_job_valid,
    output reg [31:0] o_job_addr,
    output reg [15:0] o_job_len,
    output reg o_job_sop,
    output reg o_job_crc_supplied,
    output reg o_job_rx,
    output reg [2:0] o_job_chan,
    input wire i_job_done,
    input wire [15:0] i_job_bytes,
    input wire i_job_last,
    // Interrupt
    output reg o_irq
);
    localparam S_IDLE = 3'h0;
    localparam S_RD = 3'h1;
    localparam S_CHECK = 3'h2;
    localparam S_JOB = 3'h3;
    localparam S_LINK = 3'h4;
    localparam S_WR_EOP = 3'h5;
    localparam S_WR_SOP = 3'h6;

    reg [2:0] state;
    reg [3:0] chan;
    reg [1:0] widx;
    reg [31:0] desc;
    reg [31:0] w0;
    reg [31:0] w1;
    reg [31:0] w2;
    reg [31:0] w3;
    reg [31:0] link;
    reg [31:0] sop_addr;
    reg [31:0] sop_w3;
    reg [15:0] pkt_len;
    reg pkt_eop;
    reg td;
    reg ch_adv;
    reg ch_halt;
    reg ch_done;
    reg [31:0] ch_ptr;
    reg [7:0] mask_tx;
    reg [7:0] mask_rx;
    reg [2:0] ctrl;
    reg [7:0] td_pend;
    reg [31:0] rd_mux;

    wire [2*NCH*32-1:0] heads;
    wire [2*NCH*32-1:0] lasts;
    wire [2*NCH*32-1:0] cps;
    wire [2*NCH-1:0] act;
    wire [2*NCH-1:0] raw;
    wire [2*NCH-1:0] req;
    wire any_req;
    wire [3:0] pick;
    wire is_rx = chan[3];
    wire bus_wr = i_avs_write & ~o_avs_waitrequest;
    wire [3:0] reg_ch = i_avs_address[5:2];
    wire [1:0] reg_grp = i_avs_address[7:6];
    wire [31:0] wd = i_avs_writedata;

    // ********************************
    // Channels
    // ********************************
    genvar g;
    generate
        for (g = 0; g < 2 * NCH; g = g + 1) begin : ch
            chan_queue u_q (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_head_wr(bus_wr && reg_grp == `GRP_HEAD && reg_ch == g),
                .i_cp_wr(bus_wr && reg_grp == `GRP_CP && reg_ch == g),
                .i_wdata(wd),
                .i_adv(ch_adv && chan == g),
                .i_halt(ch_halt && chan == g),
                .i_done(ch_done && chan == g),
                .i_ptr(ch_ptr),
                .o_head(heads[g*32 +: 32]),
                .o_active(act[g]),
                .o_last(lasts[g*32 +: 32]),
                .o_cp(cps[g*32 +: 32]),
                .o_raw(raw[g])
            );
        end
    endgenerate

    // Same queue walk for both directions, gated by enables
    assign req = act & {{NCH{ctrl[`CTRL_RX_EN]}},
                        {NCH{ctrl[`CTRL_TX_EN]}}};

    rr_pick #(.N(2 * NCH), .W(4)) u_pick (
        .i_req(req),
        .i_last(chan),
        .o_any(any_req),
        .o_idx(pick)
    );

    // ********************************
    // Register slave
    // ********************************
    // Read mux
    always @* begin
        rd_mux = 32'h00000000;
        if (reg_grp == `GRP_HEAD)
            rd_mux = heads[reg_ch*32 +: 32];
        else if (reg_grp == `GRP_CP)
            rd_mux = lasts[reg_ch*32 +: 32];
        else begin
            case (i_avs_address)
                `REG_TX_RAW: rd_mux = {24'h000000, raw[7:0]};
                `REG_RX_RAW: rd_mux = {24'h000000, raw[15:8]};
                `REG_TX_MSET: rd_mux = {24'h000000, mask_tx};
                `REG_RX_MSET: rd_mux = {24'h000000, mask_rx};
                `REG_CTRL: rd_mux = {29'h00000000, ctrl};
                `REG_TEARDOWN: rd_mux = {24'h000000, td_pend};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // One wait cycle, then answer
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else if (o_avs_waitrequest && (i_avs_read || i_avs_write)) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= i_avs_read ? rd_mux : 32'h00000000;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    // Masks and control
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            mask_tx <= 8'h00;
            mask_rx <= 8'h00;
            ctrl <= `CTRL_RESET;
        end else if (bus_wr) begin
            case (i_avs_address)
                `REG_TX_MSET: mask_tx <= mask_tx | wd[7:0];
                `REG_TX_MCLR: mask_tx <= mask_tx & ~wd[7:0];
                `REG_RX_MSET: mask_rx <= mask_rx | wd[7:0];
                `REG_RX_MCLR: mask_rx <= mask_rx & ~wd[7:0];
                `REG_CTRL: ctrl <= wd[2:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // Interrupt gated by mask and global enable
    always @(posedge i_clk) begin
        if (!i_reset_n)
            o_irq <= 1'b0;
        else
            o_irq <= ctrl[`CTRL_IRQ_EN] &
                     (|(raw & {mask_rx, mask_tx}));
    end

    // Teardown requests, cleared once the marked start word is written back;
    // a new request wins over the clear
    always @(posedge i_clk) begin
        if (!i_reset_n)
            td_pend <= 8'h00;
        else
            td_pend <= (td_pend & ~((state == S_WR_SOP && td && o_mm_write
                       && !i_mm_waitrequest)
                       ? (8'h01 << chan[2:0]) : 8'h00))
                     | ((bus_wr && i_avs_address == `REG_TEARDOWN)
                       ? wd[7:0] : 8'h00);
    end

    // ********************************
    // Descriptor walker
    // ********************************
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= S_IDLE;
            chan <= 4'h0;
            widx <= 2'h0;
            desc <= 32'h00000000;
            w0 <= 32'h00000000;
            w1 <= 32'h00000000;
            w2 <= 32'h00000000;
            w3 <= 32'h00000000;
            link <= 32'h00000000;
            sop_addr <= 32'h00000000;
            sop_w3 <= 32'h00000000;
            pkt_len <= 16'h0000;
            pkt_eop <= 1'b0;
            td <= 1'b0;
            ch_adv <= 1'b0;
            ch_halt <= 1'b0;
            ch_done <= 1'b0;
            ch_ptr <= 32'h00000000;
            o_mm_address <= 32'h00000000;
            o_mm_read <= 1'b0;
            o_mm_write <= 1'b0;
            o_mm_writedata <= 32'h00000000;
            o_job_valid <= 1'b0;
            o_job_addr <= 32'h00000000;
            o_job_len <= 16'h0000;
            o_job_sop <= 1'b0;
            o_job_crc_supplied <= 1'b0;
            o_job_rx <= 1'b0;
            o_job_chan <= 3'h0;
        end else begin
            ch_adv <= 1'b0;
            ch_halt <= 1'b0;
            ch_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (any_req && !ch_adv && !ch_halt) begin
                        chan <= pick;
                        desc <= heads[pick*32 +: 32];
                        widx <= 2'h0;
                        sop_addr <= 32'h00000000;
                        state <= S_RD;
                    end
                end
                S_RD: begin
                    // Four aligned words, one read each
                    o_mm_address <= desc + {28'h0000000, widx, 2'b00};
                    o_mm_read <= 1'b1;
                    if (o_mm_read && !i_mm_waitrequest) begin
                        o_mm_read <= 1'b0;
                        case (widx)
                            2'h0: w0 <= i_mm_readdata;
                            2'h1: w1 <= i_mm_readdata;
                            2'h2: w2 <= i_mm_readdata;
                            default: w3 <= i_mm_readdata;
                        endcase
                        widx <= widx + 2'h1;
                        if (widx == 2'h3)
                            state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    td <= !is_rx && td_pend[chan[2:0]];
                    if (sop_addr == 32'h00000000) begin
                        // Start of packet: ownership decided here only
                        if (!w3[`FLAG_HOLDS]) begin
                            ch_halt <= 1'b1;
                            state <= S_IDLE;
                        end else if (!is_rx && td_pend[chan[2:0]]) begin
                            sop_addr <= desc;
                            sop_w3 <= w3;
                            link <= 32'h00000000;
                            state <= S_WR_SOP;
                        end else begin
                            sop_addr <= desc;
                            sop_w3 <= w3;
                            pkt_len <= 16'h0000;
                            o_job_addr <= w1 + {16'h0000, w2[31:16]};
                            o_job_sop <= 1'b1;
                            o_job_valid <= 1'b1;
                            state <= S_JOB;
                        end
                    end else begin
                        o_job_addr <= w1;
                        o_job_sop <= 1'b0;
                        o_job_valid <= 1'b1;
                        state <= S_JOB;
                    end
                    o_job_len <= w2[15:0];
                    o_job_crc_supplied <= sop_addr == 32'h00000000
                        ? w3[`FLAG_CRC] : sop_w3[`FLAG_CRC];
                    o_job_rx <= is_rx;
                    o_job_chan <= chan[2:0];
                end
                S_JOB: begin
                    if (i_job_done) begin
                        o_job_valid <= 1'b0;
                        pkt_len <= pkt_len + (is_rx ? i_job_bytes : w2[15:0]);
                        pkt_eop <= is_rx ? i_job_last : w3[`FLAG_EOP];
                        if (is_rx ? i_job_last : w3[`FLAG_EOP]) begin
                            widx <= 2'h0;
                            state <= S_LINK;
                        end else if (w0 == 32'h00000000) begin
                            ch_halt <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            desc <= w0;
                            widx <= 2'h0;
                            state <= S_RD;
                        end
                    end
                end
                S_LINK: begin
                    // Late read of the link so a fresh patch is seen
                    o_mm_address <= desc;
                    o_mm_read <= 1'b1;
                    if (o_mm_read && !i_mm_waitrequest) begin
                        o_mm_read <= 1'b0;
                        link <= i_mm_readdata;
                        state <= (desc == sop_addr) ? S_WR_SOP : S_WR_EOP;
                    end
                end
                S_WR_EOP: begin
                    o_mm_address <= desc + `DESC_W3_OFS;
                    o_mm_writedata <= w3 | (32'h1 << `FLAG_EOP)
                        | ((link == 32'h00000000)
                           ? (32'h1 << `FLAG_EOQ) : 32'h0);
                    o_mm_write <= 1'b1;
                    if (o_mm_write && !i_mm_waitrequest) begin
                        o_mm_write <= 1'b0;
                        state <= S_WR_SOP;
                    end
                end
                S_WR_SOP: begin
                    o_mm_address <= sop_addr + `DESC_W3_OFS;
                    o_mm_writedata <= {1'b1,
                        is_rx ? pkt_eop && desc == sop_addr
                              : sop_w3[`FLAG_EOP],
                        1'b0,
                        !td && desc == sop_addr && link == 32'h0,
                        td,
                        sop_w3[`FLAG_CRC],
                        is_rx ? 10'h000 : sop_w3[25:16],
                        is_rx ? pkt_len : sop_w3[15:0]};
                    o_mm_write <= 1'b1;
                    if (o_mm_write && !i_mm_waitrequest) begin
                        o_mm_write <= 1'b0;
                        ch_done <= 1'b1;
                        ch_ptr <= desc;
                        state <= S_WR_EOP + 3'h2;
                    end
                end
                default: begin
                    // Advance or halt after completion update
                    ch_ptr <= link;
                    if (td || link == 32'h00000000)
                        ch_halt <= 1'b1;
                    else
                        ch_adv <= 1'b1;
                    td <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// *** verification/eth_dma_assertions.sv ***
`include "eth_dma_defines.vh"

// ****************
// Port checker
// ****************
module eth_dma_assertions #(
    parameter NCH = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Register bus
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire o_avs_waitrequest,
    // Descriptor bus
    input wire [31:0] o_mm_address,
    input wire o_mm_read,
    input wire o_mm_write,
    input wire [31:0] o_mm_writedata,
    input wire i_mm_waitrequest,
    // Job port and interrupt
    input wire o_job_valid,
    input wire [31:0] o_job_addr,
    input wire [15:0] o_job_len,
    input wire i_job_done,
    input wire o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic irq_en;

    // Global enable as last written by software
    always @(posedge i_clk) begin
        if (!i_reset_n)
            irq_en <= 1'b0;
        else if (i_avs_write && !o_avs_waitrequest
                 && i_avs_address == `REG_CTRL)
            irq_en <= i_avs_writedata[`CTRL_IRQ_EN];
    end

    property p_take;
        (i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest;
    endproperty
    a_take: assert property (p_take) else $error("no answer");
    property p_one;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_align;
        (o_mm_read || o_mm_write) |-> o_mm_address[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("unaligned");
    property p_hold;
        (o_mm_read || o_mm_write) && i_mm_waitrequest |=>
            (o_mm_read || o_mm_write) && $stable(o_mm_address)
            && $stable(o_mm_writedata);
    endproperty
    a_hold: assert property (p_hold) else $error("mm dropped");
    property p_excl;
        !(o_mm_read && o_mm_write);
    endproperty
    a_excl: assert property (p_excl) else $error("rd and wr");
    property p_device_holds_flag;
        o_mm_write |-> !o_mm_writedata[`FLAG_HOLDS];
    endproperty
    a_device_holds_flag: assert property (p_device_holds_flag) else $error("holds set");
    property p_job;
        o_job_valid && !i_job_done |=>
            o_job_valid && $stable(o_job_addr) && $stable(o_job_len);
    endproperty
    a_job: assert property (p_job) else $error("job changed");
    property p_jdrop;
        o_job_valid && i_job_done |=> !o_job_valid;
    endproperty
    a_jdrop: assert property (p_jdrop) else $error("job stuck");
    property p_gate;
        !irq_en && !$past(irq_en) |-> !o_irq;
    endproperty
    a_gate: assert property (p_gate) else $error("irq ungated");

    // Main scenarios reached
    c_wb: cover property (o_mm_write && !i_mm_waitrequest);
    c_irq: cover property ($rose(o_irq));
    c_job: cover property (o_job_valid && i_job_done);
endmodule

bind eth_desc_queue_dma eth_dma_assertions #(.NCH(NCH)) u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_mm_address(o_mm_address),
    .o_mm_read(o_mm_read), .o_mm_write(o_mm_write),
    .o_mm_writedata(o_mm_writedata), .i_mm_waitrequest(i_mm_waitrequest),
    .o_job_valid(o_job_valid), .o_job_addr(o_job_addr),
    .o_job_len(o_job_len), .i_job_done(i_job_done), .o_irq(o_irq)
);

// *** verification/desc_mem_model.sv ***
// ****************
// Descriptor memory
// ****************
module desc_mem_model (
    input logic i_clk,
    input logic i_reset_n,
    input logic [31:0] i_address,
    input logic i_read,
    input logic i_write,
    input logic [31:0] i_writedata,
    input logic i_slow,
    output logic [31:0] o_readdata,
    output logic o_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [3:0] cnt;

    // Answers after 1 or 4 cycles; idle data toggles each cycle
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_waitrequest <= 1'b1;
            cnt <= 4'h0;
            o_readdata <= 32'h0;
        end else if ((i_read || i_write) && o_waitrequest) begin
            if (cnt == (i_slow ? 4'h3 : 4'h0)) begin
                o_waitrequest <= 1'b0;
                cnt <= 4'h0;
                o_readdata <= i_read ? mem[i_address[9:2]]
                                     : ~o_readdata;
            end else begin
                cnt <= cnt + 4'h1;
                o_readdata <= ~o_readdata;
            end
        end else begin
            // A write lands only at the edge the master sees the answer
            if (i_write && !o_waitrequest)
                mem[i_address[9:2]] <= i_writedata;
            o_waitrequest <= 1'b1;
            o_readdata <= ~o_readdata;
        end
    end
endmodule

// *** verification/testbench.sv ***
`include "eth_dma_defines.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SOP = 32'h1 << `FLAG_SOP;
    localparam logic [31:0] EOP = 32'h1 << `FLAG_EOP;
    localparam logic [31:0] HLD = 32'h1 << `FLAG_HOLDS;
    localparam logic [31:0] END_OF_QUEUE_FLAG = 32'h1 << `FLAG_EOQ;
    localparam logic [31:0] CRC = 32'h1 << `FLAG_CRC;
    localparam logic [31:0] TD = 32'h1 << `FLAG_TD;
    logic i_clk = 1'b0, i_reset_n = 1'b0, rd = 1'b0, wr = 1'b0, awt;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, ma, mwd, mrd, jadr, r, ja [0:15];
    logic mr, mw, mwt, jv, jsop, jcrc, jrx, irq;
    logic jdone = 1'b0, jlast = 1'b1, slow = 1'b0, hold = 1'b0;
    logic [15:0] jl, jbytes = 16'h0040, jlq [0:15];
    logic [2:0] jch, jf [0:15];
    int jn = 0, bad_count = 0, cmp_count = 0, cyc = 0;

    always #4 i_clk = ~i_clk;

    eth_desc_queue_dma #(.NCH(8)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(awt),
        .o_mm_address(ma), .o_mm_read(mr), .o_mm_write(mw),
        .o_mm_writedata(mwd), .i_mm_readdata(mrd), .i_mm_waitrequest(mwt),
        .o_job_valid(jv), .o_job_addr(jadr), .o_job_len(jl),
        .o_job_sop(jsop), .o_job_crc_supplied(jcrc), .o_job_rx(jrx),
        .o_job_chan(jch), .i_job_done(jdone), .i_job_bytes(jbytes),
        .i_job_last(jlast), .o_irq(irq)
    );
    desc_mem_model u_mem (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(ma),
        .i_read(mr), .i_write(mw), .i_writedata(mwd), .i_slow(slow),
        .o_readdata(mrd), .o_waitrequest(mwt)
    );

    // Frame engine stand-in: logs each job, finishes it unless held
    always @(posedge i_clk) begin
        jdone <= 1'b0;
        if (jv && !jdone && !hold) begin
            ja[jn] <= jadr;
            jlq[jn] <= jl;
            jf[jn] <= {jrx, jsop, jcrc};
            jn <= jn + 1;
            jdone <= 1'b1;
        end
    end

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            summarize;
        end
    end

    task summarize;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            cmp_count++;
            if (g !== e) begin
                bad_count++;
                $display("[FAIL] %0t got %h want %h", $time, g, e);
            end
        end
    endtask

    // Register bus access, held until waitrequest is seen low
    task acc(input logic [7:0] a, input logic w, input logic [31:0] d);
        begin
            @(posedge i_clk);
            adr <= a;
            wd <= d;
            wr <= w;
            rd <= !w;
            @(posedge i_clk);
            while (awt !== 1'b0) @(posedge i_clk);
            r = rdat;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        begin
            acc(a, 1'b0, 32'h0);
            chk(r, e);
        end
    endtask

    task put(input logic [31:0] a, l, b, w2, w3);
        begin
            u_mem.mem[a[9:2]] = l;
            u_mem.mem[a[9:2] + 8'h1] = b;
            u_mem.mem[a[9:2] + 8'h2] = w2;
            u_mem.mem[a[9:2] + 8'h3] = w3;
        end
    endtask

    function logic [31:0] w(input logic [31:0] a);
        w = u_mem.mem[a[9:2]];
    endfunction

    // Waits for the start descriptor to be handed back
    task wait_own(input logic [31:0] a);
        begin
            while ((w(a + 32'hC) & HLD) != 32'h0) @(posedge i_clk);
            repeat (60) @(posedge i_clk);
        end
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            acc(8'(i * 4), 1'b1, 32'h0);
            rchk(8'(i * 4), 32'h0);
        end
        rchk(8'hA0, 32'h0);
        rchk(`REG_CTRL, 32'h0);
        $display("test reset done");
        put(32'h100, 32'h110, 32'h1000, 32'h000F0014, SOP | HLD | CRC | 30);
        put(32'h110, 32'h0, 32'h2003, 32'h0005000A, EOP);
        acc(`REG_CTRL, 1'b1, 32'h7);
        acc(`REG_TX_MSET, 1'b1, 32'h4);
        rchk(`REG_TX_MSET, 32'h4);
        acc(8'h08, 1'b1, 32'h100);
        wait_own(32'h100);
        chk(jn, 2);
        chk(ja[0], 32'h100F);
        chk({16'h0, jlq[0]}, 32'h14);
        chk({29'h0, jf[0]}, 32'h3);
        chk(ja[1], 32'h2003);
        chk(w(32'h11C), EOP | END_OF_QUEUE_FLAG);
        chk(w(32'h10C), SOP | CRC | 30);
        chk(w(32'h100), 32'h110);
        chk(w(32'h104), 32'h1000);
        chk(w(32'h118), 32'h0005000A);
        rchk(8'h48, 32'h110);
        rchk(`REG_TX_RAW, 32'h4);
        chk({31'h0, irq}, 32'h1);
        acc(`REG_CTRL, 1'b1, 32'h6);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        acc(`REG_CTRL, 1'b1, 32'h7);
        acc(`REG_TX_MCLR, 1'b1, 32'h4);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        rchk(`REG_TX_RAW, 32'h4);
        acc(8'h48, 1'b1, 32'h100);
        rchk(`REG_TX_RAW, 32'h4);
        acc(8'h48, 1'b1, 32'h110);
        rchk(`REG_TX_RAW, 32'h0);
        $display("test transmit done");
        put(32'h180, 32'h0, 32'h3000, 32'h00000100, SOP | HLD);
        acc(8'h34, 1'b1, 32'h180);
        wait_own(32'h180);
        chk({29'h0, jf[2]}, 32'h6);
        chk({16'h0, jlq[2]}, 32'h100);
        chk(w(32'h18C), SOP | EOP | END_OF_QUEUE_FLAG | 32'h40);
        rchk(`REG_RX_RAW, 32'h20);
        acc(`REG_RX_MSET, 1'b1, 32'h20);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h1);
        acc(8'h74, 1'b1, 32'h180);
        rchk(`REG_RX_RAW, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test receive done");
        slow <= 1'b1;
        hold <= 1'b1;
        put(32'h200, 32'h0, 32'h4000, 32'h8, SOP | EOP | HLD | 8);
        put(32'h210, 32'h0, 32'h4100, 32'h9, SOP | EOP | HLD | 9);
        acc(8'h00, 1'b1, 32'h200);
        while (jv !== 1'b1) @(posedge i_clk);
        u_mem.mem[8'h80] = 32'h210;
        hold <= 1'b0;
        wait_own(32'h210);
        chk(w(32'h20C), SOP | EOP | 8);
        chk(w(32'h21C), SOP | EOP | END_OF_QUEUE_FLAG | 9);
        put(32'h220, 32'h230, 32'h4200, 32'h7, SOP | EOP | HLD | 7);
        put(32'h230, 32'h0, 32'h4300, 32'h6, SOP | EOP | 6);
        acc(8'h00, 1'b1, 32'h220);
        wait_own(32'h220);
        chk(jn, 6);
        chk(w(32'h23C), SOP | EOP | 6);
        rchk(8'h40, 32'h220);
        $display("test append done");
        put(32'h240, 32'h0, 32'h4400, 32'h5, SOP | EOP | HLD | 5);
        acc(`REG_TEARDOWN, 1'b1, 32'h2);
        acc(8'h04, 1'b1, 32'h240);
        wait_own(32'h240);
        chk(jn, 6);
        chk(w(32'h24C), SOP | EOP | TD | 5);
        rchk(`REG_TEARDOWN, 32'h0);
        rchk(8'h44, 32'h240);
        $display("test teardown done");
        summarize;
    end
endmodule
